// file: rtl/fcp_regs.svh
`ifndef FCP_REGS_SVH
`define FCP_REGS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FCP_CTRL_OFS   8'h00
`define FCP_SECT_OFS   8'h04
`define FCP_GAP_OFS    8'h08
`define FCP_TIME_OFS   8'h0C
`define FCP_CONF_OFS   8'h10
`define FCP_RST_OFS    8'h14
`define FCP_STAT_OFS   8'h18
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FCP_CTRL_START 0
`define FCP_CTRL_WR    1
`define FCP_CTRL_HEAD  2
`define FCP_CTRL_DENS  3
`define FCP_CTRL_MTRK  4
`define FCP_CTRL_PERP  5
`define FCP_CONF_EFN   0
`define FCP_CONF_LOCK  16
`define FCP_RST_DSR    0
`define FCP_RST_DOUT   1
// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define FCP_EFN_RST    1'b1
`define FCP_THR_RST    4'h0
`define FCP_PRE_RST    8'h00
`define FCP_FIRST_SEC  8'h01
`define FCP_BASE_LEN   15'h0080
`define FCP_SPL_RST    8'hFF
// one interval count in ns, clock period in ns
`define FCP_UNIT_NS    1000
`define FCP_CLK_NS     100
`define FCP_UNIT_CYC   (`FCP_UNIT_NS / `FCP_CLK_NS)
`endif

// file: rtl/fcp_pkg.sv
package fcp_pkg;
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FCP_IDLE   = 2'b00,
    FCP_LOAD   = 2'b01,
    FCP_XFER   = 2'b10,
    FCP_UNLOAD = 2'b11
  } fcp_state_t;

  // apb request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } fcp_apb_t;

  // drive-facing outputs
  typedef struct packed {
    logic       headLoad;
    logic       headSelect;
    logic       densitySel;
    logic [7:0] sectorNum;
    logic [7:0] gap3Len;
    logic [7:0] gap2Len;
    logic       physByte;
    logic       hostByte;
    logic       zeroByte;
  } fcp_drive_t;

  // whole block state
  typedef struct packed {
    fcp_state_t  st;
    logic [11:0] cnt;
    logic [14:0] byteIdx;
    logic [7:0]  sector;
    logic        head;
    logic        headLoaded;
    logic        isWrite;
    logic        multiTrk;
    logic        density;
    logic        perp;
    logic        headSel;
    logic [7:0]  firstSec;
    logic [7:0]  lastSector;
    logic [2:0]  sizeCode;
    logic [7:0]  gap3;
    logic [7:0]  gap2;
    logic [7:0]  specLen;
    logic [7:0]  loadIntv;
    logic [7:0]  unloadIntv;
    logic        fifoEnN;
    logic [3:0]  fifo_threshold;
    logic [7:0]  precomp_start_track;
    logic        lock;
    logic [31:0] rdata;
    logic        physByte;
    logic        hostByte;
    logic        zeroByte;
  } fcp_regs_t;
endpackage

// file: rtl/fcp_core.sv
// Behaviour
// - last_sector_number ends sequencing on track
// - perpendicular mode sets gap 2 length
// - intersector_gap_length sizes gap 3
// - head_address picks side 0 or 1
// - wait head_load_interval before data transfer
// - wait head_unload_interval then unload head
// - lock keeps fifo config over soft reset
// - density_select one double, zero single density
// - multi-track: cylinder is one expanded track
// - after head 0 last sector, continue head 1
// - code zero: 128 bytes, special length transfers
// - size is 128 shifted by code, max 07
// - code zero: skip or zero-fill remainder, full CRC
// - fifo_enable_n active low, default one
`timescale 1ns/1ps
`default_nettype none
`include "fcp_regs.svh"
module fcp_core (
  // clock and reset
  input  wire logic           core_clk,
  input  wire logic           reset_n,
  // apb slave
  input  wire fcp_pkg::fcp_apb_t apbReq,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  // drive side
  output fcp_pkg::fcp_drive_t drive,
  // configuration seen by the data path
  output logic                fifoEnableN,
  output logic [3:0]          fifoThreshold,
  output logic [7:0]          precompStartTrack,
  output logic                busy
);
  import fcp_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // physical sector length for a size code
  function automatic logic [14:0] physLen(input logic [2:0] code);
    physLen = `FCP_BASE_LEN << code;
  endfunction

  // address hit on the register map
  function automatic logic addrHit(input logic [7:0] a);
    addrHit = (a == `FCP_CTRL_OFS) || (a == `FCP_SECT_OFS) ||
              (a == `FCP_GAP_OFS)  || (a == `FCP_TIME_OFS) ||
              (a == `FCP_CONF_OFS) || (a == `FCP_RST_OFS)  ||
              (a == `FCP_STAT_OFS);
  endfunction

  fcp_regs_t   s_reg;       // registered state
  fcp_regs_t   s_next;      // next state
  logic        wrEn;        // apb write in access phase
  logic        rdSetup;     // apb read setup phase
  logic        softReset;   // rate or output reset write
  logic        startReq;    // command start write
  logic [14:0] pLen;        // physical sector bytes
  logic [14:0] xLen;        // bytes passed to the host
  logic        lastByte;    // final byte of this sector
  logic        endTrack;    // expanded track exhausted
  logic [11:0] loadCyc;     // load wait in cycles
  logic [11:0] unloadCyc;   // unload wait in cycles

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // zero wait states; read data latched in setup phase
  assign pready  = 1'b1;
  assign wrEn    = apbReq.psel & apbReq.penable & apbReq.pwrite &
                   addrHit(apbReq.paddr);
  assign rdSetup = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
  assign pslverr = apbReq.psel & apbReq.penable &
                   ~addrHit(apbReq.paddr);
  assign prdata  = s_reg.rdata;
  assign softReset = wrEn && (apbReq.paddr == `FCP_RST_OFS) &&
                     (apbReq.pwdata[`FCP_RST_DSR] ||
                      apbReq.pwdata[`FCP_RST_DOUT]);
  assign startReq  = wrEn && (apbReq.paddr == `FCP_CTRL_OFS) &&
                     apbReq.pwdata[`FCP_CTRL_START];

  // ----------------------------------------------------------------
  // sector geometry
  // ----------------------------------------------------------------
  // length doubles per code step
  assign pLen = physLen(s_reg.sizeCode);
  // code zero hands over only the special length
  always_comb
  begin
    if (s_reg.sizeCode == 3'h0)
    begin
      // a special length above 128 is clipped to the sector
      if ({7'h00, s_reg.specLen} > `FCP_BASE_LEN)
        xLen = `FCP_BASE_LEN;
      else
        xLen = {7'h00, s_reg.specLen};
    end
    else
      xLen = pLen;
  end
  assign lastByte = (s_reg.byteIdx == pLen - 15'h0001);
  // track end, under head 1 if multi-track
  assign endTrack = (s_reg.sector == s_reg.lastSector) &&
                    !(s_reg.multiTrk && !s_reg.head);
  // intervals in whole clock cycles
  assign loadCyc   = 12'(s_reg.loadIntv * `FCP_UNIT_CYC);
  assign unloadCyc = 12'(s_reg.unloadIntv * `FCP_UNIT_CYC);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_next          = s_reg;
    s_next.physByte = 1'b0;
    s_next.hostByte = 1'b0;
    s_next.zeroByte = 1'b0;
    // register writes
    if (wrEn)
    begin
      case (apbReq.paddr)
        `FCP_CTRL_OFS:
        begin
          s_next.isWrite = apbReq.pwdata[`FCP_CTRL_WR];
          s_next.headSel = apbReq.pwdata[`FCP_CTRL_HEAD];
          s_next.density = apbReq.pwdata[`FCP_CTRL_DENS];
          s_next.multiTrk = apbReq.pwdata[`FCP_CTRL_MTRK];
          s_next.perp    = apbReq.pwdata[`FCP_CTRL_PERP];
        end
        `FCP_SECT_OFS:
        begin
          s_next.firstSec = apbReq.pwdata[7:0];
          s_next.lastSector = apbReq.pwdata[15:8];
          s_next.sizeCode = apbReq.pwdata[18:16];
        end
        `FCP_GAP_OFS:
        begin
          s_next.gap3 = apbReq.pwdata[7:0];
          s_next.gap2 = apbReq.pwdata[15:8];
          s_next.specLen = apbReq.pwdata[23:16];
        end
        `FCP_TIME_OFS:
        begin
          s_next.loadIntv   = apbReq.pwdata[7:0];
          s_next.unloadIntv = apbReq.pwdata[15:8];
        end
        `FCP_CONF_OFS:
        begin
          s_next.fifoEnN = apbReq.pwdata[`FCP_CONF_EFN];
          s_next.fifo_threshold = apbReq.pwdata[7:4];
          s_next.precomp_start_track  = apbReq.pwdata[15:8];
          s_next.lock    = apbReq.pwdata[`FCP_CONF_LOCK];
        end
        default:
        begin
          s_next.lock = s_reg.lock;
        end
      endcase
    end
    // sequencer
    case (s_reg.st)
      FCP_IDLE:
      begin
        if (startReq)
        begin
          s_next.head       = apbReq.pwdata[`FCP_CTRL_HEAD];
          s_next.sector     = s_reg.firstSec;
          s_next.byteIdx    = 15'h0000;
          s_next.headLoaded = 1'b1;
          s_next.cnt        = loadCyc;
          s_next.st         = FCP_LOAD;
        end
      end
      FCP_LOAD:
      begin
        // no transfer until load time runs out
        if (s_reg.cnt == 12'h000)
          s_next.st = FCP_XFER;
        else
          s_next.cnt = s_reg.cnt - 12'h001;
      end
      FCP_XFER:
      begin
        // one physical byte per cycle, crc covers all of them
        s_next.physByte = 1'b1;
        // remainder read but not passed on
        s_next.hostByte = (s_reg.byteIdx < xLen);
        s_next.zeroByte = s_reg.isWrite && (s_reg.byteIdx >= xLen);
        if (!lastByte)
          s_next.byteIdx = s_reg.byteIdx + 15'h0001;
        else
        begin
          s_next.byteIdx = 15'h0000;
          if (endTrack)
          begin
            s_next.cnt = unloadCyc;
            s_next.st  = FCP_UNLOAD;
          end
          else if (s_reg.sector == s_reg.lastSector)
          begin
            // head 0 done, go on under head 1
            s_next.head   = 1'b1;
            s_next.sector = `FCP_FIRST_SEC;
          end
          else
            s_next.sector = s_reg.sector + 8'h01;
        end
      end
      FCP_UNLOAD:
      begin
        if (startReq)
        begin
          // head still loaded, so a new command needs no load wait
          s_next.head    = apbReq.pwdata[`FCP_CTRL_HEAD];
          s_next.sector  = s_reg.firstSec;
          s_next.byteIdx = 15'h0000;
          s_next.st      = FCP_XFER;
        end
        // unload once the wait is over
        else if (s_reg.cnt == 12'h000)
        begin
          s_next.headLoaded = 1'b0;
          s_next.st         = FCP_IDLE;
        end
        else
          s_next.cnt = s_reg.cnt - 12'h001;
      end
      default:
      begin
        s_next.st = FCP_IDLE;
      end
    endcase
    // soft reset; fifo fields kept while locked
    if (softReset)
    begin
      s_next.st         = FCP_IDLE;
      s_next.headLoaded = 1'b0;
      s_next.physByte   = 1'b0;
      s_next.hostByte   = 1'b0;
      s_next.zeroByte   = 1'b0;
      if (!s_reg.lock)
      begin
        s_next.fifoEnN = `FCP_EFN_RST;
        s_next.fifo_threshold = `FCP_THR_RST;
        s_next.precomp_start_track  = `FCP_PRE_RST;
      end
    end
    // read data captured in setup, shown in access phase
    if (rdSetup)
    begin
      case (apbReq.paddr)
        `FCP_CTRL_OFS:
          s_next.rdata = {26'h0, s_reg.perp, s_reg.multiTrk, s_reg.density,
                          s_reg.headSel, s_reg.isWrite, 1'b0};
        `FCP_SECT_OFS:
          s_next.rdata = {13'h0, s_reg.sizeCode, s_reg.lastSector,
                          s_reg.firstSec};
        `FCP_GAP_OFS:
          s_next.rdata = {8'h0, s_reg.specLen, s_reg.gap2, s_reg.gap3};
        `FCP_TIME_OFS:
          s_next.rdata = {16'h0, s_reg.unloadIntv, s_reg.loadIntv};
        `FCP_CONF_OFS:
          s_next.rdata = {15'h0, s_reg.lock, s_reg.precomp_start_track,
                          s_reg.fifo_threshold, 3'h0, s_reg.fifoEnN};
        `FCP_STAT_OFS:
          s_next.rdata = {1'b0, s_reg.byteIdx, s_reg.sector,
                          4'h0, s_reg.headLoaded, s_reg.head,
                          s_reg.st};
        default:
          s_next.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_reg          <= '0;
      s_reg.firstSec <= `FCP_FIRST_SEC;
      s_reg.specLen  <= `FCP_SPL_RST;
      s_reg.fifoEnN  <= `FCP_EFN_RST;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign drive.headLoad   = s_reg.headLoaded;
  // side select follows the running head
  assign drive.headSelect = s_reg.head;
  // one is double density, zero single density
  assign drive.densitySel = s_reg.density;
  assign drive.sectorNum  = s_reg.sector;
  // gap 3 straight from its parameter
  assign drive.gap3Len    = s_reg.gap3;
  // gap 2 altered only in perpendicular mode
  assign drive.gap2Len    = s_reg.perp ? s_reg.gap2 : 8'h00;
  assign drive.physByte   = s_reg.physByte;
  assign drive.hostByte   = s_reg.hostByte;
  assign drive.zeroByte   = s_reg.zeroByte;
  assign fifoEnableN       = s_reg.fifoEnN;
  assign fifoThreshold     = s_reg.fifo_threshold;
  assign precompStartTrack = s_reg.precomp_start_track;
  assign busy              = (s_reg.st == FCP_LOAD) ||
                             (s_reg.st == FCP_XFER);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  load_wait_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (s_reg.st == FCP_LOAD && s_reg.cnt != 12'h000 && !softReset)
      |=> s_reg.st == FCP_LOAD && !s_reg.physByte)
    else $error("transfer began before load wait ended");
  unload_wait_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (s_reg.st == FCP_UNLOAD && s_reg.cnt != 12'h000 &&
     !softReset && !startReq) |=> drive.headLoad)
    else $error("head unloaded too early");
  track_end_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (s_reg.st == FCP_XFER && lastByte && endTrack && !softReset)
      |=> s_reg.st == FCP_UNLOAD)
    else $error("sequencing ran past last sector");
  head_advance_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (s_reg.st == FCP_XFER && lastByte && s_reg.multiTrk && !s_reg.head &&
     s_reg.sector == s_reg.lastSector && !softReset)
      |=> s_reg.head && s_reg.sector == `FCP_FIRST_SEC &&
          s_reg.st == FCP_XFER)
    else $error("multi-track did not move to head 1");
  host_len_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (s_reg.st == FCP_XFER && !softReset)
      |=> s_reg.hostByte == ($past(s_reg.byteIdx) < $past(xLen)))
    else $error("host byte count wrong");
  zero_fill_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    drive.zeroByte |-> drive.physByte && !drive.hostByte &&
                       $past(s_reg.isWrite))
    else $error("zero fill outside write remainder");
  size_len_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    s_reg.st == FCP_XFER
      |-> $onehot(pLen) && (pLen >> s_reg.sizeCode) == `FCP_BASE_LEN)
    else $error("sector length not 128 shifted by code");
  lock_hold_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (softReset && s_reg.lock) |=> $stable(fifoThreshold) &&
      $stable(precompStartTrack) && $stable(fifoEnableN))
    else $error("locked config changed on soft reset");
  fifo_dflt_a: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (softReset && !s_reg.lock) |=> fifoEnableN == 1'b1 &&
      !busy)
    else $error("fifo not disabled after soft reset");
endmodule
`default_nettype wire

// file: tb/fcp_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// drive-side model: counts bytes, records head and sector seen
// ----------------------------------------------------------------
module fcp_drive_model (
  // clock and clear
  input  wire logic              core_clk,
  input  wire logic              clr,
  // drive bundle from the block
  input  wire fcp_pkg::fcp_drive_t drive,
  // tallies for the bench
  output logic [15:0]            physCnt,
  output logic [15:0]            hostCnt,
  output logic [15:0]            zeroCnt,
  output logic [7:0]             lastSec,
  output logic                   firstHead,
  output logic                   lastHead,
  output logic [11:0]            loadWait,
  output logic [11:0]            unloadWait
);
  // a passive drive: it never answers, it only watches the media side
  always @(posedge core_clk)
  begin
    if (clr)
    begin
      // bench clears between transfers
      {physCnt, hostCnt, zeroCnt, lastSec} <= '0;
      {firstHead, lastHead, loadWait, unloadWait} <= '0;
    end
    else
    begin
      if (drive.physByte)
      begin
        physCnt    <= physCnt + 16'h0001;
        lastSec    <= drive.sectorNum;
        lastHead   <= drive.headSelect;
        unloadWait <= '0;
        if (physCnt == 16'h0000)
          firstHead <= drive.headSelect;
      end
      else if (drive.headLoad && physCnt != 16'h0000)
        unloadWait <= unloadWait + 12'h001;
      // settle time counted until the first byte
      if (drive.headLoad && physCnt == 16'h0000 && !drive.physByte)
        loadWait <= loadWait + 12'h001;
      if (drive.hostByte)
        hostCnt <= hostCnt + 16'h0001;
      if (drive.zeroByte)
        zeroCnt <= zeroCnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// file: tb/floppy_command_params_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fcp_regs.svh"
module floppy_command_params_bench;
  import fcp_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        core_clk;   // 10 MHz
  logic        reset_n;    // async, active low
  fcp_apb_t    req;        // apb request
  logic [31:0] prdata;     // read data
  logic        pready;     // access done
  logic        pslverr;    // unmapped access
  fcp_drive_t  drive;      // media side
  logic        fifoEnableN;
  logic [3:0]  fifoThreshold;
  logic [7:0]  precompStartTrack;
  logic        busy;
  logic        clr;        // model clear
  logic [15:0] physCnt, hostCnt, zeroCnt;
  logic [7:0]  lastSec;
  logic        firstHead, lastHead;
  logic [11:0] loadWait, unloadWait;
  logic [31:0] rd;         // last read data
  logic        err;        // last pslverr
  int          bad_count;
  int          checks_done;

  fcp_core dut (.core_clk(core_clk), .reset_n(reset_n), .apbReq(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive(drive),
    .fifoEnableN(fifoEnableN), .fifoThreshold(fifoThreshold),
    .precompStartTrack(precompStartTrack), .busy(busy));
  fcp_drive_model model (.core_clk(core_clk), .clr(clr), .drive(drive),
    .physCnt(physCnt), .hostCnt(hostCnt), .zeroCnt(zeroCnt),
    .lastSec(lastSec), .firstHead(firstHead), .lastHead(lastHead),
    .loadWait(loadWait), .unloadWait(unloadWait));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // apb master: setup, access held until pready at a rising edge
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      bad_count++;
      give_verdict();
    end
    rd  = prdata;
    err = pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    // let the write settle before the caller looks at outputs
    @(negedge core_clk);
  endtask
  // bounded wait for the sequencer to go quiet and the head to lift
  task automatic wait_idle;
    int i;
    for (i = 0; i < 40000 && (busy !== 1'b0 || drive.headLoad !== 1'b0); i++)
      @(negedge core_clk);
    if (i == 40000)
    begin
      bad_count++;
      give_verdict();
    end
  endtask
  // one transfer with its byte, sector and head expectations
  task automatic run(input logic [31:0] ctrl, input logic [31:0] sect,
                     input logic [15:0] ep, input logic [15:0] eh,
                     input logic [15:0] ez, input logic fh, input logic lh);
    @(posedge core_clk);
    clr <= 1'b1;
    @(posedge core_clk);
    clr <= 1'b0;
    // sizes and sector range stay within what a drive could hold
    apb(1'b1, `FCP_SECT_OFS, sect);
    apb(1'b1, `FCP_CTRL_OFS, ctrl);
    repeat (3) @(negedge core_clk);
    check(32'(drive.headLoad), 32'h1);
    check(32'(drive.densitySel), 32'(ctrl[3]));
    wait_idle();
    check(32'(physCnt), 32'(ep));
    check(32'(hostCnt), 32'(eh));
    check(32'(zeroCnt), 32'(ez));
    check(32'(lastSec), 32'h02);
    check(32'(firstHead), 32'(fh));
    check(32'(lastHead), 32'(lh));
    check(32'(loadWait >= 12'd20 && loadWait <= 12'd22), 32'h1);
    check(32'(unloadWait >= 12'd30 && unloadWait <= 12'd34), 32'h1);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [15:0] p;
    req         = '0;
    clr         = 1'b1;
    reset_n     = 1'b0;
    bad_count   = 0;
    checks_done = 0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    clr     <= 1'b0;
    // reset values and an unmapped place
    apb(1'b0, `FCP_CONF_OFS, 32'h0);
    check(rd, 32'h0000_0001);
    check(32'(fifoEnableN), 32'h1);
    apb(1'b0, 8'h1C, 32'h0);
    check(32'(err), 32'h1);
    check(rd, 32'h0);
    // gap lengths, gap 2 only with perpendicular mode
    apb(1'b1, `FCP_GAP_OFS, 32'h0010_2A33);
    apb(1'b1, `FCP_CTRL_OFS, 32'h0000_0020);
    repeat (2) @(negedge core_clk);
    check(32'(drive.gap3Len), 32'h33);
    check(32'(drive.gap2Len), 32'h2A);
    apb(1'b1, `FCP_CTRL_OFS, 32'h0);
    repeat (2) @(negedge core_clk);
    check(32'(drive.gap2Len), 32'h0);
    // lock off: soft reset through the rate bit restores defaults
    apb(1'b1, `FCP_CONF_OFS, 32'h0000_0A30);
    check(32'(fifoEnableN), 32'h0);
    apb(1'b1, `FCP_RST_OFS, 32'h1);
    apb(1'b0, `FCP_CONF_OFS, 32'h0);
    check(rd, 32'h0000_0001);
    // lock on: soft reset through the digital_output_register bit
    apb(1'b1, `FCP_CONF_OFS, 32'h0001_0A30);
    apb(1'b1, `FCP_RST_OFS, 32'h2);
    apb(1'b0, `FCP_CONF_OFS, 32'h0);
    check(rd, 32'h0001_0A30);
    check(32'(fifoThreshold), 32'h3);
    check(32'(precompStartTrack), 32'h0A);
    // load 2 us, unload 3 us
    apb(1'b1, `FCP_TIME_OFS, 32'h0000_0302);
    // every size code; even codes read on head 1 in DENSITY_SELECT, odd write head 0
    for (int n = 0; n < 8; n++)
    begin
      p = 16'h0100 << n;
      if (n % 2 == 0)
        run(32'h0D, (n << 16) | 32'h0201, p, n == 0 ? 16'd32 : p, 16'd0,
            1'b1, 1'b1);
      else
        run(32'h03, (n << 16) | 32'h0201, p, p, 16'd0, 1'b0, 1'b0);
    end
    // multi-track write, code zero: head 0 then head 1, zero fill
    run(32'h13, 32'h0000_0201, 16'd512, 16'd64, 16'd448, 1'b0, 1'b1);
    // status after the expanded track: idle, head 1, sector 2
    apb(1'b0, `FCP_STAT_OFS, 32'h0);
    check(rd, 32'h0000_0204);
    // soft reset in mid-load drops the head at once
    apb(1'b1, `FCP_CTRL_OFS, 32'h0000_0001);
    apb(1'b1, `FCP_RST_OFS, 32'h1);
    check(32'(drive.headLoad | busy), 32'h0);
    check(32'(fifoThreshold), 32'h3);
    give_verdict();
  end
endmodule
`default_nettype wire
